//--- include/pdl_map.svh
// Register addresses, field positions and reset values of the PHY register bank
`ifndef PDL_MAP_SVH
`define PDL_MAP_SVH
`define PDL_ADDR_DIAG      5'h12
`define PDL_ADDR_GAIN      5'h13
`define PDL_ADDR_LED       5'h17
`define PDL_ADDR_XOVER     5'h18
`define PDL_RST_DIAG       16'h0000
`define PDL_RST_GAIN       16'h4000
`define PDL_RST_LED        16'h0010
`define PDL_RST_XOVER      16'h00C0
`define PDL_DIAG_FAIL_BIT  12
`define PDL_DIAG_RESOLVED_FULL_DUPLEX_BIT  11
`define PDL_DIAG_RATE_BIT  10
`define PDL_DIAG_RECEIVE_SIGNAL_DETECT_BIT  9
`define PDL_DIAG_LOCK_BIT  8
`define PDL_LED_SEL_W      4
`define PDL_SECOND_LED_SELECT_LSB       4
`define PDL_FIRST_LED_SELECT_LSB       0
`define PDL_LED_USED_MASK  16'h00FF
`define PDL_SEL_LINK       4'h0
`define PDL_SEL_ACT        4'h1
`define PDL_SEL_100        4'h5
`define PDL_SEL_10         4'h6
`define PDL_SEL_FDX        4'h7
`define PDL_SEL_LINK_BLINK 4'h8
`endif

//--- include/pdl_pkg.sv
// Types shared by the PHY register bank
package pdl_pkg;
  typedef struct packed {
    logic link_good;
    logic activity;
    logic speed_100;
    logic full_duplex;
  } pdl_link_s;
  typedef struct packed {
    logic an_done;
    logic an_fail;
    logic an_resolved_full_duplex;
    logic an_rate;
    logic rx_sd;
    logic rx_lock;
  } pdl_an_s;
  typedef enum logic [1:0] {PDL_IDLE, PDL_READ, PDL_WRITE} pdl_op_e;
endpackage

//--- core/pdl_led_mux.sv
// LED source selector for one LED output
`timescale 1ns/1ps
`default_nettype none
`include "pdl_map.svh"
module pdl_led_mux (
  input  wire logic                        clk_i,
  input  wire logic                        nrst_i,
  input  wire logic [`PDL_LED_SEL_W-1:0]   sel_i,
  input  wire pdl_pkg::pdl_link_s          link_i,
  input  wire logic                        blink_i,
  output logic                             led_o
);
  logic led_r;
  logic led_nxt;
  // ****************************************
  // Source select
  // ****************************************
  always_comb begin
    led_nxt = 1'b0;
    unique case (sel_i)
      `PDL_SEL_LINK:       led_nxt = link_i.link_good;
      `PDL_SEL_ACT:        led_nxt = link_i.activity;
      `PDL_SEL_100:        led_nxt = link_i.link_good & link_i.speed_100;
      `PDL_SEL_10:         led_nxt = link_i.link_good & ~link_i.speed_100;
      `PDL_SEL_FDX:        led_nxt = link_i.full_duplex;
      `PDL_SEL_LINK_BLINK: led_nxt = link_i.link_good &
                                     ~(link_i.activity & blink_i);
      // Reserved codes leave the LED dark
      default:             led_nxt = 1'b0; // RULE15
    endcase
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      led_r <= 1'b0;
    end else begin
      led_r <= led_nxt;
    end
  end
  assign led_o = led_r;
endmodule
`default_nettype wire

//--- core/pdl_regs.sv
// PHY diagnostic, gain, LED and crossover management registers
// How it works
// RULE1: Read-only diagnostic register at 0x12, zero after reset.
// RULE2: Diagnostic holds speed, duplex and failure of the last negotiation.
// RULE3: Writable transceiver control register at 0x13, resets to 0x4000.
// RULE4: Transceiver control holds transmit gain, driven out to transmitter.
// RULE5: Writable LED configuration register at 0x17, resets to 0x0010.
// RULE6: Bits 7:4 select second LED source, reset 0x1.
// RULE7: Codes: link, activity, reserved, 100, 10, duplex, link with blink.
// RULE8: Bits 3:0 select first LED source, reset 0x0.
// RULE9: First LED uses same codes, defaults to link good.
// RULE10: Software keeps LED bits 15:8 by read-modify-write.
// RULE11: Writable crossover control register at 0x18, resets to 0x00C0.
// RULE12: Crossover register drives the pair-swap mux control outputs.
// RULE13: Registers reached by address reads and writes over management port.
// RULE14: Failure flag bit 12 clears on read; other bits follow state.
// RULE15: Reserved LED codes keep the LED output inactive.
`timescale 1ns/1ps
`default_nettype none
`include "pdl_map.svh"
module pdl_regs #(
  parameter int BLINK_DIV = 4
) (
  input  wire logic                REF_CLK_I,
  input  wire logic                NRST_I,
  input  wire logic                MGMT_RD_I,
  input  wire logic                MGMT_WR_I,
  input  wire logic [4:0]          MGMT_ADDR_I,
  input  wire logic [15:0]         MGMT_WDATA_I,
  output logic      [15:0]         MGMT_RDATA_O,
  output logic                     MGMT_RVALID_O,
  input  wire pdl_pkg::pdl_an_s    AN_I,
  input  wire pdl_pkg::pdl_link_s  LINK_I,
  output logic      [15:0]         TX_GAIN_CTRL_O,
  output logic      [15:0]         XOVER_CTRL_O,
  output logic                     FIRST_LED_SELECT_O,
  output logic                     SECOND_LED_SELECT_O
);
  // ****************************************
  // Parameter check
  // ****************************************
  // A wider counter would make the blink too slow to see
  if (BLINK_DIV < 1 || BLINK_DIV > 24) begin : g_bad_blink_div
    $error("BLINK_DIV out of range");
  end

  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction

  function automatic logic [`PDL_LED_SEL_W-1:0] led_field(
    input logic [15:0] word,
    input int          lsb
  );
    led_field = word[lsb +: `PDL_LED_SEL_W];
  endfunction

  logic [15:0] diag_r,  diag_nxt;
  logic [15:0] gain_r,  gain_nxt;
  logic [15:0] led_r,   led_nxt;
  logic [15:0] xover_r, xover_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [BLINK_DIV-1:0] blink_r, blink_nxt;
  logic        blink_phase;
  pdl_pkg::pdl_op_e op;

  // ****************************************
  // Request decode
  // ****************************************
  // Write wins a collision so a read never sees a half-written word
  always_comb begin
    op = pdl_pkg::PDL_IDLE;
    if (MGMT_WR_I) begin
      op = pdl_pkg::PDL_WRITE;
    end else if (MGMT_RD_I) begin
      op = pdl_pkg::PDL_READ;
    end
  end

  // ****************************************
  // Diagnostic register
  // ****************************************
  always_comb begin
    diag_nxt = diag_r;
    // Speed and duplex move only when a negotiation ends
    if (AN_I.an_done) begin
      diag_nxt[`PDL_DIAG_RESOLVED_FULL_DUPLEX_BIT] = AN_I.an_resolved_full_duplex; // RULE2
      diag_nxt[`PDL_DIAG_RATE_BIT] = AN_I.an_rate; // RULE2
    end
    diag_nxt[`PDL_DIAG_RECEIVE_SIGNAL_DETECT_BIT] = AN_I.rx_sd; // RULE14
    diag_nxt[`PDL_DIAG_LOCK_BIT] = AN_I.rx_lock; // RULE14
    // Diagnostic register ignores writes
    if (op == pdl_pkg::PDL_READ && hit(MGMT_ADDR_I, `PDL_ADDR_DIAG)) begin
      diag_nxt[`PDL_DIAG_FAIL_BIT] = 1'b0; // RULE14
    end
    // A new failure wins over the clear of the same cycle
    if (AN_I.an_done && AN_I.an_fail) begin
      diag_nxt[`PDL_DIAG_FAIL_BIT] = 1'b1; // RULE2
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      diag_r <= `PDL_RST_DIAG; // RULE1
    end else begin
      diag_r <= diag_nxt;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_comb begin
    gain_nxt  = gain_r;
    led_nxt   = led_r;
    xover_nxt = xover_r;
    if (op == pdl_pkg::PDL_WRITE) begin
      if (hit(MGMT_ADDR_I, `PDL_ADDR_GAIN)) begin
        gain_nxt = MGMT_WDATA_I; // RULE3 RULE4
      end
      if (hit(MGMT_ADDR_I, `PDL_ADDR_LED)) begin
        // Upper byte dropped; software keeps it by read-modify-write
        led_nxt = MGMT_WDATA_I & `PDL_LED_USED_MASK; // RULE5 RULE10
      end
      if (hit(MGMT_ADDR_I, `PDL_ADDR_XOVER)) begin
        xover_nxt = MGMT_WDATA_I; // RULE11 RULE12
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      gain_r  <= `PDL_RST_GAIN; // RULE3
      led_r   <= `PDL_RST_LED; // RULE5 RULE6 RULE8
      xover_r <= `PDL_RST_XOVER; // RULE11
    end else begin
      gain_r  <= gain_nxt;
      led_r   <= led_nxt;
      xover_r <= xover_nxt;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Read data stays put until the next read so a slow master can fetch it
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    if (op == pdl_pkg::PDL_READ) begin
      rvalid_nxt = 1'b1; // RULE13
      rdata_nxt  = 16'h0000;
      if (hit(MGMT_ADDR_I, `PDL_ADDR_DIAG)) begin
        rdata_nxt = diag_r; // RULE1
      end
      if (hit(MGMT_ADDR_I, `PDL_ADDR_GAIN)) begin
        rdata_nxt = gain_r;
      end
      if (hit(MGMT_ADDR_I, `PDL_ADDR_LED)) begin
        rdata_nxt = led_r & `PDL_LED_USED_MASK;
      end
      if (hit(MGMT_ADDR_I, `PDL_ADDR_XOVER)) begin
        rdata_nxt = xover_r;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // ****************************************
  // Blink pacing
  // ****************************************
  // Free-running; both LEDs share one phase so they blink together
  always_comb begin
    blink_nxt = blink_r + 1'b1;
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      blink_r <= '0;
    end else begin
      blink_r <= blink_nxt;
    end
  end

  assign blink_phase = blink_r[BLINK_DIV-1];

  // ****************************************
  // Outputs
  // ****************************************
  assign MGMT_RDATA_O   = rdata_r;
  assign MGMT_RVALID_O  = rvalid_r;
  assign TX_GAIN_CTRL_O = gain_r; // RULE4
  assign XOVER_CTRL_O   = xover_r; // RULE12

  // ****************************************
  // LED drivers
  // ****************************************
  pdl_led_mux u_first_led_select (
    .clk_i   (REF_CLK_I),
    .nrst_i  (NRST_I),
    .sel_i   (led_field(led_r, `PDL_FIRST_LED_SELECT_LSB)), // RULE8 RULE9
    .link_i  (LINK_I),
    .blink_i (blink_phase),
    .led_o   (FIRST_LED_SELECT_O)
  );
  pdl_led_mux u_second_led_select (
    .clk_i   (REF_CLK_I),
    .nrst_i  (NRST_I),
    .sel_i   (led_field(led_r, `PDL_SECOND_LED_SELECT_LSB)), // RULE6 RULE7
    .link_i  (LINK_I),
    .blink_i (blink_phase),
    .led_o   (SECOND_LED_SELECT_O)
  );
endmodule
`default_nettype wire

//--- verification/pdl_regs_chk.sv
// Port checker of the PHY register bank
`timescale 1ns/1ps
`default_nettype none
module pdl_regs_chk (
  input wire logic        REF_CLK_I,
  input wire logic        NRST_I,
  input wire logic        MGMT_RD_I,
  input wire logic        MGMT_WR_I,
  input wire logic [4:0]  MGMT_ADDR_I,
  input wire logic [15:0] MGMT_WDATA_I,
  input wire logic [15:0] MGMT_RDATA_O,
  input wire logic        MGMT_RVALID_O,
  input wire logic [15:0] TX_GAIN_CTRL_O,
  input wire logic [15:0] XOVER_CTRL_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);
  // Write wins a collision, so only a lone read counts
  logic rd_ok;
  assign rd_ok = MGMT_RD_I && !MGMT_WR_I;
  chk_rd_valid: assert property (
    rd_ok |=> MGMT_RVALID_O) else $error("read not answered");
  chk_rd_idle: assert property (
    !rd_ok |=> !MGMT_RVALID_O) else $error("spurious read valid");
  chk_rst_vals: assert property (
    $rose(NRST_I) |-> TX_GAIN_CTRL_O == 16'h4000
      && XOVER_CTRL_O == 16'h00C0) else $error("bad reset value");
  chk_gain_wr: assert property (
    MGMT_WR_I && MGMT_ADDR_I == 5'h13 |=>
      TX_GAIN_CTRL_O == $past(MGMT_WDATA_I)) else $error("gain lost");
  chk_gain_hold: assert property (
    !(MGMT_WR_I && MGMT_ADDR_I == 5'h13) |=>
      $stable(TX_GAIN_CTRL_O)) else $error("gain moved");
  chk_xover_wr: assert property (
    MGMT_WR_I && MGMT_ADDR_I == 5'h18 |=>
      XOVER_CTRL_O == $past(MGMT_WDATA_I)) else $error("xover lost");
  chk_unmapped_rd: assert property (
    rd_ok && !(MGMT_ADDR_I inside {5'h12, 5'h13, 5'h17, 5'h18})
      |=> MGMT_RDATA_O == 16'h0000) else $error("unmapped not 0");
  chk_diag_rsvd: assert property (
    rd_ok && MGMT_ADDR_I == 5'h12 |=> MGMT_RDATA_O[15:13] == 3'h0
      && MGMT_RDATA_O[7:0] == 8'h00) else $error("diag reserved");
  chk_led_rsvd: assert property (
    rd_ok && MGMT_ADDR_I == 5'h17 |=> MGMT_RDATA_O[15:8] == 8'h00)
    else $error("led reserved");
  chk_rdata_hold: assert property (
    !rd_ok |=> $stable(MGMT_RDATA_O)) else $error("read data moved");
endmodule
`default_nettype wire

//--- verification/pdl_mac_model.sv
// MAC-side management master model
`timescale 1ns/1ps
`default_nettype none
module pdl_mac_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output logic             rd_o = 1'b0,
  output logic             wr_o = 1'b0,
  output logic [4:0]       addr_o = 5'h1F,
  output logic [15:0]      wdata_o = 16'h0000
);
  // Released fields go inverted so a stale value never looks valid
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // Callers keep the upper bits of a read-back word on rewrite
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    d = 'x;
    repeat (4) begin
      @(posedge clk_i);
      if (rvalid_i === 1'b1) begin
        d = rdata_i;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench of the PHY register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rd, wr, rvalid, first_led_select, second_led_select;
  logic nrst = 1'b0;
  logic [4:0] addr;
  logic [15:0] rdata, d;
  logic [15:0] wdata, gain, xover, ones;
  pdl_pkg::pdl_an_s an = '0;
  pdl_pkg::pdl_link_s link = 4'b1110;
  int error_cnt = 0;
  int tests_run = 0;
  // Address, write data, expected read-back
  logic [36:0] rows [5] = '{{5'h13, 16'hA55A, 16'hA55A},
    {5'h18, 16'h3C3C, 16'h3C3C}, {5'h17, 16'hFF81, 16'h0081},
    {5'h12, 16'hFFFF, 16'h0000}, {5'h0A, 16'h5555, 16'h0000}};
  logic [20:0] rst_v [4] = '{{5'h12, 16'h0000}, {5'h13, 16'h4000},
    {5'h17, 16'h0010}, {5'h18, 16'h00C0}};
  // Link inputs, then the expected LED for selector codes 8 down to 0
  logic [12:0] lc [2] = '{{4'b1010, 9'h121}, {4'b0101, 9'h082}};
  pdl_regs #(.BLINK_DIV(2)) i_dut (.REF_CLK_I(clk), .NRST_I(nrst),
    .MGMT_RD_I(rd), .MGMT_WR_I(wr), .MGMT_ADDR_I(addr),
    .MGMT_WDATA_I(wdata), .MGMT_RDATA_O(rdata), .MGMT_RVALID_O(rvalid),
    .AN_I(an), .LINK_I(link), .TX_GAIN_CTRL_O(gain), .XOVER_CTRL_O(xover),
    .FIRST_LED_SELECT_O(first_led_select), .SECOND_LED_SELECT_O(second_led_select));
  pdl_mac_model i_mac (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid),
    .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      i_mac.wr(rows[i][36:32], rows[i][31:16]);
      i_mac.rd(rows[i][36:32], d);
      chk(d, rows[i][15:0]);
    end
    chk(gain, 16'hA55A);
    chk(xover, 16'h3C3C);
    // Mid-run reset must bring back every default
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk({14'h0, second_led_select, first_led_select}, 16'h0003);
    chk(gain, 16'h4000);
    chk(xover, 16'h00C0);
    foreach (rst_v[i]) begin
      i_mac.rd(rst_v[i][20:16], d);
      chk(d, rst_v[i][15:0]);
    end
    foreach (lc[k]) begin
      link <= lc[k][12:9];
      for (int s = 0; s < 9; s++) begin
        i_mac.rd(5'h17, d);
        i_mac.wr(5'h17, {d[15:8], s[3:0], s[3:0]});
        repeat (3) @(posedge clk);
        chk({14'h0, second_led_select, first_led_select}, {14'h0, {2{lc[k][s]}}});
      end
    end
    // Steady traffic on the blink code lights half of each blink period
    link <= 4'b1100;
    i_mac.wr(5'h17, 16'h0088);
    repeat (3) @(posedge clk);
    ones = 16'h0000;
    repeat (4) begin
      @(posedge clk);
      ones = ones + {15'h0, first_led_select} + {15'h0, second_led_select};
    end
    chk(ones, 16'h0004);
    an <= 6'b111011;
    @(posedge clk);
    an.an_done <= 1'b0;
    repeat (2) @(posedge clk);
    i_mac.rd(5'h12, d);
    chk(d, 16'h1B00);
    i_mac.rd(5'h12, d);
    chk(d, 16'h0B00);
    // Speed and duplex hold between negotiations; a failure beats the clear
    an <= 6'b000100;
    repeat (2) @(posedge clk);
    fork
      i_mac.rd(5'h12, d);
      begin
        @(posedge clk);
        an <= 6'b110100;
        @(posedge clk);
        an.an_done <= 1'b0;
      end
    join
    chk(d, 16'h0800);
    i_mac.rd(5'h12, d);
    chk(d, 16'h1400);
    i_mac.rd(5'h12, d);
    chk(d, 16'h0400);
    results();
  end
endmodule
bind pdl_regs pdl_regs_chk i_chk (.REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I),
  .MGMT_RD_I(MGMT_RD_I), .MGMT_WR_I(MGMT_WR_I), .MGMT_ADDR_I(MGMT_ADDR_I),
  .MGMT_WDATA_I(MGMT_WDATA_I), .MGMT_RDATA_O(MGMT_RDATA_O),
  .MGMT_RVALID_O(MGMT_RVALID_O), .TX_GAIN_CTRL_O(TX_GAIN_CTRL_O),
  .XOVER_CTRL_O(XOVER_CTRL_O));
`default_nettype wire
